//--- safety_muting_controller_tb.sv
`timescale 1ns/10ps
module safety_muting_controller_tb;
    typedef struct {logic w; logic [31:0] a, d, x;} smc_row_t;
    localparam int MSC = 2;
    logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire hready, hreadyout, hresp;
    wire [31:0] hrdata;
    logic muted_stop_input_a = 1'h1, muted_stop_input_b = 1'h1;
    logic supplemental_stop_input_a = 1'h0;
    logic supplemental_stop_input_b = 1'h1;
    logic reset_contact = 1'h0, mute_window_input = 1'h1;
    logic mute_sensor_a1 = 1'h0, mute_sensor_a2 = 1'h0;
    logic mute_sensor_b1 = 1'h0, mute_sensor_b2 = 1'h0;
    logic feedback_link = 1'h0, one_ch = 1'h0, welded = 1'h0;
    wire contactor_feedback_input_1, contactor_feedback_input_2;
    wire [1:0] safety_output_pair;
    wire led_green, led_yellow, led_red, mute_lamp, disp_dash;
    wire muted_stop_ind_a, muted_stop_ind_b, disp_num_en;
    wire [5:0] disp_value;
    int err_count = 0;
    int n_tests = 0;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    smc_top #(.MS_CYC(MSC)) DUT (.*);
    smc_contactor_model u_contactor (.*);
    // Free-running 250 MHz clock
    initial forever #2 clk = ~clk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] x, g);
        n_tests++;
        if (g !== x) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Bounded wait for bus ready; a hang ends the run
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'h1 && i < 20);
        if (hready !== 1'h1) begin
            err_count++;
            tally_and_finish;
        end
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask : ahb

    task automatic press(input int ms);
        reset_contact <= 1'h1;
        tick(ms * MSC);
        reset_contact <= 1'h0;
        tick(6);
    endtask : press

    task automatic mute(input int gap);
        mute_sensor_a1 <= 1'h1;
        tick(gap * MSC + 1);
        mute_sensor_a2 <= 1'h1;
        tick(6);
    endtask : mute

    task automatic unmute;
        mute_sensor_a1 <= 1'h0;
        mute_sensor_a2 <= 1'h0;
        tick(6);
    endtask : unmute

    // Open and reclose the supplemental stop
    task automatic cyc;
        supplemental_stop_input_a <= 1'h0;
        tick(8);
        supplemental_stop_input_a <= 1'h1;
        tick(8);
    endtask : cyc

    // Collect levels seen on yellow, red and dash over a while
    task automatic flash(output logic [2:0] hi, lo);
        hi = 3'h0;
        lo = 3'h0;
        repeat (1100) begin
            @(posedge clk);
            hi = hi | {led_yellow, led_red, disp_dash};
            lo = lo | ~{led_yellow, led_red, disp_dash};
        end
    endtask : flash

    // Main sequence: register rows, then behaviour by hand
    initial begin
        smc_row_t rows [9];
        int pr [3];
        int hmax [4];
        int hmin [4];
        logic [31:0] r;
        logic [2:0] hi, lo;
        int i;
        // Press lengths in ms; countdown bounds after about 2 s
        pr = '{100, 2500, 500};
        hmax = '{0, 30, 60, 30};
        hmin = '{0, 27, 57, 29};
        rows = '{'{1'h0, 32'h0, 32'h0, 32'h1}, '{1'h0, 32'h4, 32'h0, 32'hC1},
            '{1'h0, 32'h8, 32'h0, 32'h80}, '{1'h0, 32'hC, 32'h0, 32'h0},
            '{1'h1, 32'hC, 32'hFFFFFFFF, 32'h0},
            '{1'h1, 32'h0, 32'hFFFFFFFF, 32'h0},
            '{1'h0, 32'h0, 32'h0, 32'h3F}, '{1'h1, 32'h0, 32'h1, 32'h0},
            '{1'h0, 32'h0, 32'h0, 32'h1}};
        tick(4);
        rst_n <= 1'h1;
        tick(1);
        foreach (rows[k]) begin
            ahb(rows[k].w, rows[k].a, rows[k].d, r);
            if (!rows[k].w) chk("reg", rows[k].x, r);
        end
        supplemental_stop_input_a <= 1'h1;
        tick(6);
        chk("on", 32'h7, {safety_output_pair, led_green});
        chk("dash", 32'h1, disp_dash);
        muted_stop_input_b <= 1'h0;
        tick(4);
        chk("stop", 32'h0, {safety_output_pair, led_green});
        muted_stop_input_b <= 1'h1;
        tick(6);
        chk("reclose", 32'h3, safety_output_pair);
        // Manual reset with short, long and good presses
        ahb(1'h1, 32'h0, 32'h0, r);
        supplemental_stop_input_b <= 1'h0;
        tick(4);
        chk("stop", 32'h0, safety_output_pair);
        supplemental_stop_input_b <= 1'h1;
        flash(hi, lo);
        chk("yellow", 32'h3, {hi[2] & lo[2], disp_dash});
        foreach (pr[k]) begin
            press(pr[k]);
            chk("press", k == 2 ? 32'h7 : 32'h0,
                {safety_output_pair, led_green});
        end
        // Each backdoor length counts in its own unit
        for (i = 1; i < 4; i++) begin
            ahb(1'h1, 32'h0, {26'h0, i[1:0], 4'h1}, r);
            mute(10);
            chk("lamp", 32'h1, mute_lamp);
            tick(2000 * MSC);
            chk("count", 32'h1, disp_num_en && disp_value <= hmax[i]
                && disp_value >= hmin[i]);
            unmute;
        end
        mute(3200);
        chk("gap", 32'h0, mute_lamp);
        unmute;
        mute(2900);
        muted_stop_input_a <= 1'h0;
        muted_stop_input_b <= 1'h0;
        tick(4);
        chk("muted", 32'h1C, {safety_output_pair, led_green,
            muted_stop_ind_a, muted_stop_ind_b});
        muted_stop_input_a <= 1'h1;
        muted_stop_input_b <= 1'h1;
        tick(4);
        chk("ind", 32'h3, {muted_stop_ind_a, muted_stop_ind_b});
        unmute;
        chk("end", 32'h7, {mute_lamp, safety_output_pair, led_green});
        ahb(1'h1, 32'h0, 32'h1, r);
        mute(10);
        flash(hi, lo);
        chk("dash", 32'h1, hi[0] & lo[0] & ~disp_num_en);
        unmute;
        // Second pair first blocks the mute
        ahb(1'h1, 32'h0, 32'h3, r);
        mute_sensor_b1 <= 1'h1;
        mute_sensor_b2 <= 1'h1;
        tick(4);
        mute(10);
        chk("onedir", 32'h0, mute_lamp);
        unmute;
        mute_sensor_b1 <= 1'h0;
        mute_sensor_b2 <= 1'h0;
        // Window gating and rearming
        ahb(1'h1, 32'h0, 32'h5, r);
        mute_window_input <= 1'h0;
        tick(4);
        mute(10);
        chk("win", 32'h0, mute_lamp);
        unmute;
        mute_window_input <= 1'h1;
        tick(4);
        mute(10);
        chk("win", 32'h1, mute_lamp);
        unmute;
        mute(10);
        chk("rearm", 32'h0, mute_lamp);
        unmute;
        mute_window_input <= 1'h0;
        tick(4);
        mute_window_input <= 1'h1;
        tick(4);
        mute(10);
        mute_window_input <= 1'h0;
        tick(4);
        chk("winopen", 32'h1, mute_lamp);
        unmute;
        mute_window_input <= 1'h1;
        // Feedback modes and faults
        ahb(1'h1, 32'h0, 32'h1, r);
        one_ch <= 1'h1;
        cyc;
        chk("fb2", 32'h0, safety_output_pair);
        flash(hi, lo);
        chk("red", 32'h1, hi[1] & lo[1]);
        ahb(1'h1, 32'h0, 32'h9, r);
        cyc;
        chk("fb1ch", 32'h3, safety_output_pair);
        // Welded contact at a manual reset: outputs withheld
        welded <= 1'h1;
        ahb(1'h1, 32'h0, 32'h8, r);
        cyc;
        press(300);
        chk("weld", 32'h0, safety_output_pair);
        ahb(1'h1, 32'h0, 32'h9, r);
        feedback_link <= 1'h1;
        cyc;
        chk("link", 32'h3, safety_output_pair);
        // Second reset in mid-run
        rst_n <= 1'h0;
        tick(2);
        chk("rst", 32'h0, {safety_output_pair, led_green, mute_lamp});
        rst_n <= 1'h1;
        welded <= 1'h0;
        feedback_link <= 1'h0;
        one_ch <= 1'h0;
        tick(1);
        ahb(1'h0, 32'h0, 32'h0, r);
        chk("ctrl", 32'h1, r);
        // Backdoor expiry with stop held
        ahb(1'h1, 32'h0, 32'h11, r);
        tick(6);
        mute(10);
        muted_stop_input_a <= 1'h0;
        i = 0;
        while (safety_output_pair !== 2'h0 && i < 70000) begin
            @(posedge clk);
            i++;
        end
        if (i >= 70000) err_count++;
        tick(4);
        chk("expiry", 32'h0, {safety_output_pair, mute_lamp});
        tally_and_finish;
    end
endmodule : safety_muting_controller_tb

//--- smc_consts.svh
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// Clock rate and derived cycles per millisecond
`define SMC_CLK_MHZ 250
`define SMC_US_PER_MS 1000
`define SMC_MS_CYC (`SMC_CLK_MHZ * `SMC_US_PER_MS)
// Time base divisions
`define SMC_SEC_MS 1000
`define SMC_MIN_SEC 60
`define SMC_FLASH_MS 250
// Reset contact window, in ms
`define SMC_RST_MIN_MS 12'h0FA
`define SMC_RST_MAX_MS 12'h7D0
// Mute sensor pairing window, in ms
`define SMC_MUTE_GAP_MS 12'hBB8
// Backdoor timer lengths (seconds, seconds, minutes)
`define SMC_BD_S30 6'h1E
`define SMC_BD_S60 6'h3C
`define SMC_BD_M30 6'h1E
// Register byte offsets
`define SMC_CTRL_OFS 32'h00000000
`define SMC_STAT_OFS 32'h00000004
`define SMC_DISP_OFS 32'h00000008
// CTRL fields
`define SMC_CTRL_AUTO 0
`define SMC_CTRL_ONEDIR 1
`define SMC_CTRL_WIN 2
`define SMC_CTRL_FB1 3
`define SMC_CTRL_BD_LO 4
`define SMC_CTRL_BD_HI 5
`define SMC_CTRL_MASK 32'h0000003F
`define SMC_CTRL_RST 32'h00000001
`endif

//--- smc_contactor_model.sv
`timescale 1ns/10ps
module smc_contactor_model (
    input wire clk,
    input wire rst_n,
    input wire [1:0] safety_output_pair,
    input wire one_ch,
    input wire welded,
    output logic contactor_feedback_input_1,
    output logic contactor_feedback_input_2
);
    logic [2:0] coil_q;
    // Coils pull in and drop out a few cycles after the outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            coil_q <= 3'h0;
        else
            coil_q <= {coil_q[1:0], &safety_output_pair};
    end
    // N.C. contacts open while energised; a weld keeps the first open
    always_comb begin
        contactor_feedback_input_1 = ~coil_q[2] & ~welded;
        contactor_feedback_input_2 = one_ch ? 1'h0 : ~coil_q[2];
    end
endmodule : smc_contactor_model

//--- smc_pkg.sv
package smc_pkg;
    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_WAIT = 5'h02,
        ST_RUN = 5'h04,
        ST_MUTE = 5'h08,
        ST_FAULT = 5'h10
    } smc_state_t;
    typedef enum logic [1:0] {
        BD_OFF = 2'h0,
        BD_S30 = 2'h1,
        BD_S60 = 2'h2,
        BD_M30 = 2'h3
    } smc_bd_t;
endpackage : smc_pkg

//--- smc_tick_if.sv
`timescale 1ns/10ps
interface smc_tick_if;
    logic ms;
    logic sec;
    logic min;
    logic flash;
    modport gen (output ms, output sec, output min, output flash);
    modport sink (input ms, input sec, input min, input flash);
endinterface : smc_tick_if

//--- smc_timebase.sv
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_timebase #(
    parameter int MS_CYC = `SMC_MS_CYC
) (
    input wire clk,
    input wire rst_n,
    smc_tick_if.gen tk
);
    logic [19:0] cyc_q;
    logic [9:0] ms_q;
    logic [5:0] sec_q;
    logic [7:0] fl_q;
    logic ms_q1;
    logic sec_q1;
    logic min_q1;
    logic flash_q;

    // Millisecond prescaler, one pulse per wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q <= 20'h00000;
            ms_q1 <= 1'b0;
        end else begin
            ms_q1 <= (cyc_q == 20'(MS_CYC - 1));
            if (cyc_q == 20'(MS_CYC - 1)) begin
                cyc_q <= 20'h00000;
            end else begin
                cyc_q <= cyc_q + 20'h00001;
            end
        end
    end

    // Seconds and minutes chained on the ms pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_q <= 10'h000;
            sec_q <= 6'h00;
            sec_q1 <= 1'b0;
            min_q1 <= 1'b0;
        end else begin
            sec_q1 <= 1'b0;
            min_q1 <= 1'b0;
            if (ms_q1) begin
                if (ms_q == 10'(`SMC_SEC_MS - 1)) begin
                    ms_q <= 10'h000;
                    sec_q1 <= 1'b1;
                    if (sec_q == 6'(`SMC_MIN_SEC - 1)) begin
                        sec_q <= 6'h00;
                        min_q1 <= 1'b1;
                    end else begin
                        sec_q <= sec_q + 6'h01;
                    end
                end else begin
                    ms_q <= ms_q + 10'h001;
                end
            end
        end
    end

    // Indicator flash, 2 Hz square wave
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fl_q <= 8'h00;
            flash_q <= 1'b0;
        end else if (ms_q1) begin
            if (fl_q == 8'(`SMC_FLASH_MS - 1)) begin
                fl_q <= 8'h00;
                flash_q <= ~flash_q;
            end else begin
                fl_q <= fl_q + 8'h01;
            end
        end
    end

    assign tk.ms = ms_q1;
    assign tk.sec = sec_q1;
    assign tk.min = min_q1;
    assign tk.flash = flash_q;
endmodule : smc_timebase

//--- smc_top.sv
`timescale 1ns/10ps
`include "smc_consts.svh"
module smc_top
    import smc_pkg::*;
#(
    parameter int MS_CYC = `SMC_MS_CYC
) (
    input wire clk,
    input wire rst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire muted_stop_input_a,
    input wire muted_stop_input_b,
    input wire supplemental_stop_input_a,
    input wire supplemental_stop_input_b,
    input wire reset_contact,
    input wire mute_sensor_a1,
    input wire mute_sensor_a2,
    input wire mute_sensor_b1,
    input wire mute_sensor_b2,
    input wire mute_window_input,
    input wire contactor_feedback_input_1,
    input wire contactor_feedback_input_2,
    input wire feedback_link,
    output logic [1:0] safety_output_pair,
    output logic led_green,
    output logic led_yellow,
    output logic led_red,
    output logic mute_lamp,
    output logic muted_stop_ind_a,
    output logic muted_stop_ind_b,
    output logic disp_dash,
    output logic disp_num_en,
    output logic [5:0] disp_value
);
    smc_tick_if tk ();
    smc_state_t st_q;
    smc_state_t st_d;
    smc_bd_t bd_sel;
    logic [31:0] ctrl_q;
    logic [31:0] adr_q;
    logic [31:0] rdata_q;
    logic wr_q;
    logic [11:0] rst_ms_q;
    logic rst_prev_q;
    logic [11:0] gap_ms_q;
    logic pair_q;
    logic b_first_q;
    logic win_prev_q;
    logic win_armed_q;
    logic [5:0] bd_q;
    logic [1:0] out_q;
    logic green_q;
    logic yellow_q;
    logic red_q;
    logic lamp_q;
    logic ind_a_q;
    logic ind_b_q;
    logic dash_q;
    logic num_en_q;
    logic [5:0] val_q;

    smc_timebase #(.MS_CYC(MS_CYC)) u_tb (
        .clk(clk),
        .rst_n(rst_n),
        .tk(tk)
    );

    // Full-word address match; used by write and read paths
    function automatic logic is_ofs(logic [31:0] a, logic [31:0] o);
        is_ofs = (a == o);
    endfunction : is_ofs

    // Configuration fields
    wire auto_rst = ctrl_q[`SMC_CTRL_AUTO];
    wire one_dir = ctrl_q[`SMC_CTRL_ONEDIR];
    wire win_en = ctrl_q[`SMC_CTRL_WIN];
    wire feedback_mode_switch = ctrl_q[`SMC_CTRL_FB1];
    assign bd_sel = smc_bd_t'(ctrl_q[`SMC_CTRL_BD_HI:`SMC_CTRL_BD_LO]);

    // Stop interfaces give go only with both channels closed
    wire msi_ok = muted_stop_input_a & muted_stop_input_b;
    wire ssi_ok = supplemental_stop_input_a & supplemental_stop_input_b;
    wire all_ok = msi_ok & ssi_ok;

    wire fb_ok = feedback_link | (feedback_mode_switch ?
        (contactor_feedback_input_1 & ~contactor_feedback_input_2) :
        (contactor_feedback_input_1 & contactor_feedback_input_2));

    // AHB-Lite slave: zero wait states, always OKAY
    wire acc = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    // Address phase capture and read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            adr_q <= 32'h00000000;
            rdata_q <= 32'h00000000;
        end else begin
            wr_q <= acc & hwrite;
            if (acc) begin
                adr_q <= haddr;
            end
            if (acc & ~hwrite) begin
                if (is_ofs(haddr, `SMC_CTRL_OFS)) begin
                    rdata_q <= ctrl_q;
                end else if (is_ofs(haddr, `SMC_STAT_OFS)) begin
                    rdata_q <= {23'h0, b_first_q, win_armed_q,
                        fb_ok, out_q[0], st_q};
                end else if (is_ofs(haddr, `SMC_DISP_OFS)) begin
                    rdata_q <= {24'h000000, dash_q, num_en_q, val_q};
                end else begin
                    rdata_q <= 32'h00000000;
                end
            end
        end
    end

    // Control register write in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SMC_CTRL_RST;
        end else if (wr_q && is_ofs(adr_q, `SMC_CTRL_OFS)) begin
            ctrl_q <= hwdata & `SMC_CTRL_MASK;
        end
    end

    // reset press timing
    // Saturates just past the limit so a long press is never accepted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ms_q <= 12'h000;
            rst_prev_q <= 1'b0;
        end else begin
            rst_prev_q <= reset_contact;
            if (!reset_contact) begin
                rst_ms_q <= 12'h000;
            end else if (tk.ms && rst_ms_q <= `SMC_RST_MAX_MS) begin
                rst_ms_q <= rst_ms_q + 12'h001;
            end
        end
    end

    // Accepted on the opening edge only
    wire rst_ok = rst_prev_q & ~reset_contact &
        (rst_ms_q >= `SMC_RST_MIN_MS) & (rst_ms_q <= `SMC_RST_MAX_MS);

    // time between first-pair sensors
    // Counts while exactly one is active, frozen once both are
    wire a_any = mute_sensor_a1 | mute_sensor_a2;
    wire a_both = mute_sensor_a1 & mute_sensor_a2;
    wire b_any = mute_sensor_b1 | mute_sensor_b2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ms_q <= 12'h000;
            pair_q <= 1'b0;
        end else begin
            pair_q <= a_both;
            if (!a_any) begin
                gap_ms_q <= 12'h000;
            end else if (!a_both && tk.ms &&
                    gap_ms_q <= `SMC_MUTE_GAP_MS) begin
                gap_ms_q <= gap_ms_q + 12'h001;
            end
        end
    end

    // second pair seen before first
    // Set needs a second-pair sensor, so all sensors dropping together clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            b_first_q <= 1'b0;
        end else if (b_any && !a_any) begin
            b_first_q <= 1'b1;
        end else if (!a_any && !b_any) begin
            b_first_q <= 1'b0;
        end
    end

    wire mute_go;

    // window armed by a fresh closure
    // Consumed at mute start; opening mid-mute changes nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_prev_q <= 1'b0;
            win_armed_q <= 1'b0;
        end else begin
            win_prev_q <= mute_window_input;
            if (mute_window_input && !win_prev_q) begin
                win_armed_q <= 1'b1;
            end else if (mute_go) begin
                win_armed_q <= 1'b0;
            end
        end
    end

    assign mute_go = (st_q == ST_RUN) && all_ok && a_both && !pair_q &&
        (gap_ms_q <= `SMC_MUTE_GAP_MS) && !(one_dir && b_first_q) &&
        (!win_en || win_armed_q);

    // minute steps for the long timer
    // First step may fall early: ticks are free running
    wire bd_step = (bd_sel == BD_M30) ? tk.min : tk.sec;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bd_q <= 6'h00;
        end else if (mute_go) begin
            unique case (bd_sel)
                BD_S30: bd_q <= `SMC_BD_S30;
                BD_S60: bd_q <= `SMC_BD_S60;
                BD_M30: bd_q <= `SMC_BD_M30;
                BD_OFF: bd_q <= 6'h00;
            endcase
        end else if (st_q == ST_MUTE && bd_step && bd_q != 6'h00) begin
            bd_q <= bd_q - 6'h01;
        end
    end

    wire bd_exp = (bd_sel != BD_OFF) && (bd_q == 6'h00);

    // Main sequence
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_OFF: begin
                if (all_ok) begin
                    if (!auto_rst) begin
                        st_d = ST_WAIT;
                    end else if (fb_ok) begin
                        st_d = ST_RUN;
                    end else begin
                        st_d = ST_FAULT;
                    end
                end
            end
            ST_WAIT: begin
                if (!all_ok) begin
                    st_d = ST_OFF;
                end else if (rst_ok) begin
                    st_d = fb_ok ? ST_RUN : ST_FAULT;
                end
            end
            ST_RUN: begin
                if (!all_ok) begin
                    st_d = ST_OFF;
                end else if (mute_go) begin
                    st_d = ST_MUTE;
                end
            end
            ST_MUTE: begin
                if (!ssi_ok) begin
                    st_d = ST_OFF;
                end else if (bd_exp || !a_any) begin
                    st_d = msi_ok ? ST_RUN : ST_OFF;
                end
            end
            ST_FAULT: begin
                if (fb_ok && !all_ok) begin
                    st_d = ST_OFF;
                end
            end
            default: st_d = ST_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // Pins and state lamps follow the next state, in step with st_q; stop indicators copy their inputs
    // outputs and green in run and mute
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 2'h0;
            green_q <= 1'b0;
            yellow_q <= 1'b0;
            red_q <= 1'b0;
            lamp_q <= 1'b0;
            ind_a_q <= 1'b0;
            ind_b_q <= 1'b0;
        end else begin
            out_q <= {2{st_d == ST_RUN || st_d == ST_MUTE}};
            green_q <= (st_d == ST_RUN || st_d == ST_MUTE);
            yellow_q <= (st_d == ST_WAIT) & tk.flash;
            red_q <= (st_d == ST_FAULT) & tk.flash;
            lamp_q <= (st_d == ST_MUTE);
            ind_a_q <= muted_stop_input_a;
            ind_b_q <= muted_stop_input_b;
        end
    end

    // Display one cycle behind the state
    // unlimited mute: flashing dash
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dash_q <= 1'b0;
            num_en_q <= 1'b0;
            val_q <= 6'h00;
        end else if (st_q == ST_MUTE && bd_sel != BD_OFF) begin
            dash_q <= 1'b0;
            num_en_q <= 1'b1;
            val_q <= bd_q;
        end else begin
            dash_q <= (st_q == ST_MUTE) ? tk.flash : 1'b1;
            num_en_q <= 1'b0;
            val_q <= 6'h00;
        end
    end

    assign safety_output_pair = out_q;
    assign led_green = green_q;
    assign led_yellow = yellow_q;
    assign led_red = red_q;
    assign mute_lamp = lamp_q;
    assign muted_stop_ind_a = ind_a_q;
    assign muted_stop_ind_b = ind_b_q;
    assign disp_dash = dash_q;
    assign disp_num_en = num_en_q;
    assign disp_value = val_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    auto_on_a: assert property (st_q == ST_OFF && auto_rst && all_ok
        && fb_ok |=> out_q == 2'h3 && green_q ##1 dash_q)
        else $error("auto reset did not turn outputs on");
    wait_flash_a: assert property (st_q == ST_WAIT && st_d == ST_WAIT
        |=> yellow_q == $past(tk.flash) && !out_q[0])
        else $error("yellow not flashing while reset awaited");
    short_press_a: assert property (st_q == ST_WAIT &&
        $fell(reset_contact) && rst_ms_q < `SMC_RST_MIN_MS |=> !out_q[0])
        else $error("short reset press accepted");
    stop_off_a: assert property (st_q == ST_RUN && !all_ok
        |=> out_q == 2'h0 && st_q == ST_OFF)
        else $error("stop did not drop outputs");
    mute_gap_a: assert property ($rose(st_q == ST_MUTE) |->
        $past(gap_ms_q) <= `SMC_MUTE_GAP_MS && $past(a_both))
        else $error("mute started outside sensor window");
    mute_lamp_a: assert property (st_q == ST_MUTE |-> lamp_q)
        else $error("mute lamp off while muted");
    muted_hold_a: assert property (st_q == ST_MUTE && !msi_ok &&
        ssi_ok && a_any && !bd_exp |=> out_q == 2'h3 && green_q
        && !ind_a_q)
        else $error("muted stop affected outputs");
    bd_show_a: assert property (st_q == ST_MUTE && bd_sel != BD_OFF
        |=> num_en_q && val_q == $past(bd_q))
        else $error("countdown not shown");
    one_dir_a: assert property (st_q == ST_RUN && one_dir &&
        b_first_q |=> st_q != ST_MUTE)
        else $error("mute from wrong direction");
    win_gate_a: assert property (st_q == ST_RUN && win_en &&
        !win_armed_q |=> st_q != ST_MUTE)
        else $error("mute without window");
    expire_a: assert property (st_q == ST_MUTE && bd_exp &&
        !msi_ok |=> out_q == 2'h0 ##1 !lamp_q)
        else $error("expired mute kept outputs on");
    fb_block_a: assert property (st_q == ST_WAIT && rst_ok &&
        all_ok && !fb_ok |=> st_q == ST_FAULT && out_q == 2'h0)
        else $error("outputs on with open feedback");

    mute_cv: cover property (st_q == ST_RUN ##1 st_q == ST_MUTE);
    reset_cv: cover property (st_q == ST_WAIT ##1 st_q == ST_RUN);
    fault_cv: cover property (st_q == ST_FAULT);
    expire_cv: cover property (st_q == ST_MUTE && bd_exp);
endmodule : smc_top
